//--- shared/lbc_pkg.sv
package lbc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned LF_HZ     = 32_000;
  localparam int unsigned UPDATE_MS = 8;
  localparam int unsigned LF_DIV    = CLK_HZ / LF_HZ;
  localparam int unsigned UPD_LF    = (LF_HZ * UPDATE_MS) / 1000;
  localparam int unsigned PWM_STEPS = 15;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_SEL_LO   = 4'h0;
  localparam logic [3:0] OFS_SEL_MID  = 4'h1;
  localparam logic [3:0] OFS_SEL_HI   = 4'h2;
  localparam logic [3:0] OFS_FADE_ON  = 4'h3;
  localparam logic [3:0] OFS_FULL_ON  = 4'h4;
  localparam logic [3:0] OFS_FADE_OFF = 4'h5;
  localparam logic [3:0] OFS_OFF1     = 4'h6;
  localparam logic [3:0] OFS_OFF2     = 4'h7;
  localparam logic [3:0] OFS_PEAK     = 4'h8;
  localparam logic [3:0] OFS_MASTER   = 4'h9;
  localparam logic [3:0] OFS_INIT     = 4'hA;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] DUR_RST    = 8'h44;
  localparam logic [7:0] PEAK_RST   = 8'hFF;
  localparam logic [7:0] MASTER_RST = 8'h0F;
  localparam logic [7:0] SEL_RST    = 8'h00;
  localparam int unsigned MST_SRC_LSB = 4;
  localparam int unsigned MST_ONE_LSB = 6;
  localparam int unsigned INIT_GO_A   = 3;
  localparam int unsigned INIT_GO_B   = 7;

  // Pin state codes {hi, mid, lo}
  localparam logic [2:0] SEL_FIX_A  = 3'h2;
  localparam logic [2:0] SEL_FIX_B  = 3'h3;
  localparam logic [2:0] SEL_FULL   = 3'h4;
  localparam logic [2:0] SEL_MASTER = 3'h5;
  localparam logic [2:0] SEL_BLK_A  = 3'h6;
  localparam logic [2:0] SEL_BLK_B  = 3'h7;

  // Two nibbles of a per-bank register
  typedef struct packed {
    logic [3:0] grp_b;
    logic [3:0] grp_a;
  } lbc_nib_s;

  // Regions of the intensity cycle, coded as the start code
  typedef enum logic [2:0] {
    RG_A1 = 3'b000, RG_B1 = 3'b001, RG_C1 = 3'b010, RG_D = 3'b011,
    RG_A2 = 3'b100, RG_B2 = 3'b101, RG_C2 = 3'b110, RG_E = 3'b111
  } lbc_region_e;

  // Duration code to count of 8 ms update steps
  function automatic logic [10:0] dur_steps(input logic [3:0] code);
    unique case (code)
      4'h0: dur_steps = 11'h000;
      4'h1: dur_steps = 11'h008;
      4'h2: dur_steps = 11'h010;
      4'h3: dur_steps = 11'h018;
      4'h4: dur_steps = 11'h020;
      4'h5: dur_steps = 11'h030;
      4'h6: dur_steps = 11'h040;
      4'h7: dur_steps = 11'h060;
      4'h8: dur_steps = 11'h080;
      4'h9: dur_steps = 11'h0C0;
      4'hA: dur_steps = 11'h100;
      4'hB: dur_steps = 11'h180;
      4'hC: dur_steps = 11'h200;
      4'hD: dur_steps = 11'h2D0;
      4'hE: dur_steps = 11'h3F8;
      4'hF: dur_steps = 11'h7F8;
    endcase
  endfunction : dur_steps

endpackage : lbc_pkg

//--- design/lbc_tick_div.sv
`timescale 1ns/10ps
module lbc_tick_div #(
  parameter int unsigned DIV = 2
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  // Count enable and tick
  input  wire logic en_in,
  output logic      tick_out
);

  localparam int unsigned W = (DIV > 2) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt_q;

  // Divide enabled cycles by DIV, one-cycle tick on wrap
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else if (en_in) begin
      tick_out <= (cnt_q == W'(DIV - 1));
      cnt_q    <= (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + 1'b1;
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule : lbc_tick_div

//--- design/lbc_pwm.sv
`timescale 1ns/10ps
module lbc_pwm #(
  parameter int unsigned CH = 7
) (
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                srst_in,
  // Levels and pin enables
  input  wire logic [CH-1:0][3:0]  level_in,
  output logic      [CH-1:0]       oe_out
);

  logic [3:0] phase_q;

  // Shared phase 0..14, so code n drives n of 15 slots
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= (phase_q == 4'(lbc_pkg::PWM_STEPS - 1)) ? 4'h0 : phase_q + 4'h1;
    end
  end

  // Per-pin compare, registered drive enable
  for (genvar i = 0; i < CH; i++) begin : g_ch
    always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
        oe_out[i] <= 1'b0;
      end else begin
        oe_out[i] <= (level_in[i] > phase_q);
      end
    end
  end

endmodule : lbc_pwm

//--- design/lbc_led_ctrl.sv
// Behaviour
// - Off regions D and E hold zero intensity
// - Bits 7-4 group_b, 3-0 group_a codes
// - Peak nibble is fully-on region duty
// - Peak nibble sets fixed-peak on brightness
// - Intensity recomputed every 8 ms
// - Brightness code n gives n/15 duty
// - Mode register bits 3-0 master level
// - Bits 4/5 choose master or bank peak
// - Bits 6/7 choose continuous or one-shot
// - Init bits 2-0 start, bit 3 go group_a
// - Init bits 6-4 start, bit 7 go group_b
// - Start code maps to regions A1..E
// - Init write restarts banks at region start
// - One-shot holds level at region end
// - Stopped outputs detach, peak or off
// - Stop rewrites upper select register bits
// - Generator keeps running after one-shot
// - Duration codes decode to documented milliseconds
// - Cycle is two pulses, two off periods
`timescale 1ns/10ps
module lbc_led_ctrl #(
  parameter int unsigned LF_DIV  = lbc_pkg::LF_DIV,
  parameter int unsigned UPD_DIV = lbc_pkg::UPD_LF,
  parameter int unsigned PINS    = 7
) (
  // Clock and reset
  input  wire logic            ref_clk_in,
  input  wire logic            srst_in,
  // Byte register port
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  input  wire logic [3:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  output logic      [7:0]      reg_rdata_out,
  // Open-drain LED pins
  input  wire logic [PINS-1:0] led_pin_in,
  output logic      [PINS-1:0] led_pin_out,
  output logic      [PINS-1:0] led_pin_oe_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lbc_pkg::lbc_nib_s   fade_on_q, full_on_q, fade_off_q, off1_q, off2_q, peak_q;
  logic [7:0]          master_q;
  logic [7:0]          sel_lo_q, sel_mid_q, sel_hi_q;
  logic                lf_tick, upd_tick;
  lbc_pkg::lbc_region_e region_q [2];
  logic [10:0]         cnt_q [2];
  logic [3:0]          level_q [2];
  logic                armed_q [2];
  logic [10:0]         len_w [2];
  logic [3:0]          pk_w [2];
  logic [3:0]          ramp_w [2];
  logic [1:0]          init_go, region_end, stop_w, final_on;
  logic [PINS-1:0][3:0] pin_lvl_d, pin_lvl_q;
  logic [PINS-1:0]     pin_seen_q;

  // Pick one bank's nibble
  function automatic logic [3:0] nib_of(input lbc_pkg::lbc_nib_s v, input int g);
    nib_of = (g == 0) ? v.grp_a : v.grp_b;
  endfunction : nib_of

  // Linear ramp peak*cnt/len, zero for an empty region
  function automatic logic [3:0] ramp(input logic [3:0] pk, input logic [10:0] cnt,
                                      input logic [10:0] len);
    logic [14:0] prod;
    prod = 15'({11'h000, pk} * {4'h0, cnt});
    ramp = (len == 11'h000) ? 4'h0 : 4'(prod / {4'h0, len});
  endfunction : ramp

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // Low-frequency tick, then the 8 ms update tick from it
  lbc_tick_div #(.DIV(LF_DIV)) u_lf_div (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .en_in      (1'b1),
    .tick_out   (lf_tick)
  );

  lbc_tick_div #(.DIV(UPD_DIV)) u_upd_div (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .en_in      (lf_tick),
    .tick_out   (upd_tick)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Timing, peak and master registers
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      fade_on_q  <= lbc_pkg::DUR_RST;
      full_on_q  <= lbc_pkg::DUR_RST;
      fade_off_q <= lbc_pkg::DUR_RST;
      off1_q     <= lbc_pkg::DUR_RST;
      off2_q     <= lbc_pkg::DUR_RST;
      peak_q     <= lbc_pkg::PEAK_RST;
      master_q   <= lbc_pkg::MASTER_RST;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        lbc_pkg::OFS_FADE_ON:  fade_on_q  <= reg_wdata_in;
        lbc_pkg::OFS_FULL_ON:  full_on_q  <= reg_wdata_in;
        lbc_pkg::OFS_FADE_OFF: fade_off_q <= reg_wdata_in;
        lbc_pkg::OFS_OFF1:     off1_q     <= reg_wdata_in;
        lbc_pkg::OFS_OFF2:     off2_q     <= reg_wdata_in;
        lbc_pkg::OFS_PEAK:     peak_q     <= reg_wdata_in;
        lbc_pkg::OFS_MASTER:   master_q   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Select registers; a one-shot stop overrides a same-cycle write
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sel_lo_q  <= lbc_pkg::SEL_RST;
      sel_mid_q <= lbc_pkg::SEL_RST;
      sel_hi_q  <= lbc_pkg::SEL_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == lbc_pkg::OFS_SEL_LO) begin
        sel_lo_q <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == lbc_pkg::OFS_SEL_MID) begin
        sel_mid_q <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == lbc_pkg::OFS_SEL_HI) begin
        sel_hi_q <= reg_wdata_in;
      end
      for (int i = 0; i < PINS; i++) begin
        for (int g = 0; g < 2; g++) begin
          if (stop_w[g] && sel_hi_q[i] && sel_mid_q[i] && (sel_lo_q[i] == g[0])) begin
            sel_hi_q[i]  <= 1'b0;
            sel_mid_q[i] <= final_on[g];
          end
        end
      end
    end
  end

  // Read data; write-only and unmapped offsets read zero
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        lbc_pkg::OFS_SEL_LO:   reg_rdata_out <= sel_lo_q;
        lbc_pkg::OFS_SEL_MID:  reg_rdata_out <= sel_mid_q;
        lbc_pkg::OFS_SEL_HI:   reg_rdata_out <= sel_hi_q;
        lbc_pkg::OFS_FADE_ON:  reg_rdata_out <= fade_on_q;
        lbc_pkg::OFS_FULL_ON:  reg_rdata_out <= full_on_q;
        lbc_pkg::OFS_FADE_OFF: reg_rdata_out <= fade_off_q;
        lbc_pkg::OFS_OFF1:     reg_rdata_out <= off1_q;
        lbc_pkg::OFS_OFF2:     reg_rdata_out <= off2_q;
        lbc_pkg::OFS_PEAK:     reg_rdata_out <= peak_q;
        lbc_pkg::OFS_MASTER:   reg_rdata_out <= master_q;
        default:               reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pattern generators
  // ----------------------------------------------------------------
  assign init_go[0] = reg_wr_in && (reg_addr_in == lbc_pkg::OFS_INIT)
                      && reg_wdata_in[lbc_pkg::INIT_GO_A];
  assign init_go[1] = reg_wr_in && (reg_addr_in == lbc_pkg::OFS_INIT)
                      && reg_wdata_in[lbc_pkg::INIT_GO_B];

  for (genvar g = 0; g < 2; g++) begin : g_bank
    // Region length, peak source and ramp value
    always_comb begin
      unique case (region_q[g])
        lbc_pkg::RG_A1, lbc_pkg::RG_A2: len_w[g] = lbc_pkg::dur_steps(nib_of(fade_on_q, g));
        lbc_pkg::RG_B1, lbc_pkg::RG_B2: len_w[g] = lbc_pkg::dur_steps(nib_of(full_on_q, g));
        lbc_pkg::RG_C1, lbc_pkg::RG_C2: len_w[g] = lbc_pkg::dur_steps(nib_of(fade_off_q, g));
        lbc_pkg::RG_D:  len_w[g] = lbc_pkg::dur_steps(nib_of(off1_q, g));
        lbc_pkg::RG_E:  len_w[g] = lbc_pkg::dur_steps(nib_of(off2_q, g));
      endcase
      pk_w[g]   = master_q[lbc_pkg::MST_SRC_LSB + g] ? master_q[3:0]
                                                     : nib_of(peak_q, g);
      ramp_w[g] = ramp(pk_w[g], cnt_q[g], len_w[g]);
    end

    assign region_end[g] = ({1'b0, cnt_q[g]} + 12'h001) >= {1'b0, len_w[g]};
    assign stop_w[g]     = upd_tick && region_end[g] && armed_q[g] && !init_go[g];
    assign final_on[g]   = (region_q[g] == lbc_pkg::RG_A1) || (region_q[g] == lbc_pkg::RG_B1)
                        || (region_q[g] == lbc_pkg::RG_A2) || (region_q[g] == lbc_pkg::RG_B2);

    // Region sequencer; keeps cycling after a one-shot stop
    always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
        region_q[g] <= lbc_pkg::RG_A1;
        cnt_q[g]    <= 11'h000;
        armed_q[g]  <= 1'b0;
      end else if (init_go[g]) begin
        region_q[g] <= lbc_pkg::lbc_region_e'(reg_wdata_in[4*g +: 3]);
        cnt_q[g]    <= 11'h000;
        armed_q[g]  <= master_q[lbc_pkg::MST_ONE_LSB + g];
      end else if (upd_tick) begin
        if (region_end[g]) begin
          region_q[g] <= lbc_pkg::lbc_region_e'(region_q[g] + 3'h1);
          cnt_q[g]    <= 11'h000;
          if (stop_w[g]) begin
            armed_q[g] <= 1'b0;
          end
        end else begin
          cnt_q[g] <= cnt_q[g] + 11'h001;
        end
      end
    end

    // Bank intensity, refreshed on the update tick
    always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
        level_q[g] <= 4'h0;
      end else if (upd_tick) begin
        unique case (region_q[g])
          lbc_pkg::RG_A1, lbc_pkg::RG_A2: level_q[g] <= ramp_w[g];
          lbc_pkg::RG_B1, lbc_pkg::RG_B2: level_q[g] <= pk_w[g];
          lbc_pkg::RG_C1, lbc_pkg::RG_C2: level_q[g] <= pk_w[g] - ramp_w[g];
          lbc_pkg::RG_D, lbc_pkg::RG_E:   level_q[g] <= 4'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin levels and drive
  // ----------------------------------------------------------------
  // Per-pin brightness from its state code
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      unique case ({sel_hi_q[i], sel_mid_q[i], sel_lo_q[i]})
        lbc_pkg::SEL_FIX_A:  pin_lvl_d[i] = pk_w[0];
        lbc_pkg::SEL_FIX_B:  pin_lvl_d[i] = pk_w[1];
        lbc_pkg::SEL_FULL:   pin_lvl_d[i] = 4'hF;
        lbc_pkg::SEL_MASTER: pin_lvl_d[i] = master_q[3:0];
        lbc_pkg::SEL_BLK_A:  pin_lvl_d[i] = level_q[0];
        lbc_pkg::SEL_BLK_B:  pin_lvl_d[i] = level_q[1];
        default:             pin_lvl_d[i] = 4'h0;
      endcase
    end
  end

  // Latch pin levels on the update tick
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_lvl_q <= '0;
    end else if (upd_tick) begin
      pin_lvl_q <= pin_lvl_d;
    end
  end

  // Pin level as seen, and a constant low drive value
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_seen_q  <= '0;
      led_pin_out <= '0;
    end else begin
      pin_seen_q  <= led_pin_in;
      led_pin_out <= '0;
    end
  end

  lbc_pwm #(.CH(PINS)) u_pwm (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .level_in   (pin_lvl_q),
    .oe_out     (led_pin_oe_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_init_a;
    reg_wr_in && reg_addr_in == lbc_pkg::OFS_INIT && reg_wdata_in[lbc_pkg::INIT_GO_A];
  endsequence
  sequence s_init_b;
    reg_wr_in && reg_addr_in == lbc_pkg::OFS_INIT && reg_wdata_in[lbc_pkg::INIT_GO_B];
  endsequence

  chk_init_start_a: assert property (
    s_init_a |=> region_q[0] == $past(reg_wdata_in[2:0]) && cnt_q[0] == 11'h000)
    else $error("group_a start region not taken");
  chk_init_start_b: assert property (
    s_init_b |=> region_q[1] == $past(reg_wdata_in[6:4]) && cnt_q[1] == 11'h000)
    else $error("group_b start region not taken");
  chk_off_dark: assert property (
    upd_tick && (region_q[0] == lbc_pkg::RG_D || region_q[0] == lbc_pkg::RG_E)
    |=> level_q[0] == 4'h0)
    else $error("off region not dark");
  chk_full_peak: assert property (
    upd_tick && region_q[1] == lbc_pkg::RG_B1 |=> level_q[1] == $past(pk_w[1]))
    else $error("fully-on level differs from peak");
  chk_master_pin: assert property (
    upd_tick && {sel_hi_q[0], sel_mid_q[0], sel_lo_q[0]} == lbc_pkg::SEL_MASTER
    |=> pin_lvl_q[0] == $past(master_q[3:0]))
    else $error("master level not applied");
  chk_pwm_dark: assert property (
    pin_lvl_q[0] == 4'h0 ##1 pin_lvl_q[0] == 4'h0 |-> !led_pin_oe_out[0])
    else $error("pin driven at zero level");
  chk_pwm_full: assert property (
    pin_lvl_q[0] == 4'hF ##1 pin_lvl_q[0] == 4'hF |-> led_pin_oe_out[0])
    else $error("pin released at full level");
  chk_shot_rewrite: assert property (
    stop_w[0] && sel_hi_q[0] && sel_mid_q[0] && !sel_lo_q[0]
    |=> !sel_hi_q[0] && sel_mid_q[0] == $past(final_on[0]))
    else $error("one-shot select rewrite missing");
  chk_shot_runs: assert property (
    stop_w[0] |=> !armed_q[0] && region_q[0] == $past(region_q[0]) + 3'h1)
    else $error("generator stopped after one-shot");
  chk_cnt_paced: assert property (
    !upd_tick && !init_go[0] |=> $stable(cnt_q[0]) && $stable(region_q[0]))
    else $error("region counter moved off tick");

  // Static pin modes and one-shot arming; pins share one decoder
  chk_fix_peak_a: assert property (
    upd_tick && {sel_hi_q[0], sel_mid_q[0], sel_lo_q[0]} == lbc_pkg::SEL_FIX_A
    |=> pin_lvl_q[0] == $past(pk_w[0]))
    else $error("group_a fixed-peak level not applied");
  chk_fix_peak_b: assert property (
    upd_tick && {sel_hi_q[1], sel_mid_q[1], sel_lo_q[1]} == lbc_pkg::SEL_FIX_B
    |=> pin_lvl_q[1] == $past(pk_w[1]))
    else $error("group_b fixed-peak level not applied");
  chk_full_pin: assert property (
    upd_tick && {sel_hi_q[1], sel_mid_q[1], sel_lo_q[1]} == lbc_pkg::SEL_FULL
    |=> pin_lvl_q[1] == 4'hF)
    else $error("full-on pin not at full level");
  chk_shot_arm_a: assert property (
    s_init_a |=> armed_q[0] == $past(master_q[lbc_pkg::MST_ONE_LSB]))
    else $error("group_a one-shot arming not taken");
  chk_shot_arm_b: assert property (
    s_init_b |=> armed_q[1] == $past(master_q[lbc_pkg::MST_ONE_LSB + 1]))
    else $error("group_b one-shot arming not taken");

endmodule : lbc_led_ctrl

//--- verif/lbc_led_load.sv
`timescale 1ns/10ps
module lbc_led_load #(
  parameter int unsigned PINS = 7
) (
  // Drive from the device
  input  wire logic [PINS-1:0] pin_drv_in,
  input  wire logic [PINS-1:0] pin_oe_in,
  // Resolved pin level and lit LEDs
  output logic      [PINS-1:0] pin_lvl_out,
  output logic      [PINS-1:0] lit_out
);
  // LED to the supply acts as a pull-up; a released pin floats high, LED dark
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_lvl_out[i] = pin_oe_in[i] ? pin_drv_in[i] : 1'b1;
      lit_out[i]     = ~pin_lvl_out[i];
    end
  end
endmodule : lbc_led_load

//--- verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic       ref_clk_in   = 1'b0;
  logic       srst_in      = 1'b1;
  logic       reg_wr_in    = 1'b0;
  logic       reg_rd_in    = 1'b0;
  logic [3:0] reg_addr_in  = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic [6:0] led_pin_in;
  logic [6:0] led_pin_out;
  logic [6:0] led_pin_oe_out;
  logic [6:0] lit;
  int         n_errors     = 0;
  int         comparisons  = 0;
  int         cyc          = 0;

  // ------------------------------------------------------------
  // Device and LED load
  // ------------------------------------------------------------
  lbc_led_ctrl #(.LF_DIV(2), .UPD_DIV(2), .PINS(7)) lbc_led_ctrl_i (
    .ref_clk_in    (ref_clk_in),
    .srst_in       (srst_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_rdata_out (reg_rdata_out),
    .led_pin_in    (led_pin_in),
    .led_pin_out   (led_pin_out),
    .led_pin_oe_out(led_pin_oe_out)
  );

  lbc_led_load #(.PINS(7)) lbc_led_load_i (
    .pin_drv_in (led_pin_out),
    .pin_oe_in  (led_pin_oe_out),
    .pin_lvl_out(led_pin_in),
    .lit_out    (lit)
  );

  // Clock, and a ceiling on the run length
  always #12.5 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    reg_wr_in    = 1'b1;
    reg_addr_in  = a;
    reg_wdata_in = d;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(negedge ref_clk_in);
    reg_rd_in   = 1'b1;
    reg_addr_in = a;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    chk(reg_rdata_out, exp);
  endtask : rd_chk

  task automatic set_sel(input logic [7:0] lo, input logic [7:0] mid, input logic [7:0] hi);
    wr(lbc_pkg::OFS_SEL_LO, lo);
    wr(lbc_pkg::OFS_SEL_MID, mid);
    wr(lbc_pkg::OFS_SEL_HI, hi);
  endtask : set_sel

  // Lit cycles of pins 0 and 1 over ten PWM periods of 15 clocks
  task automatic duty(input logic [7:0] exp_a, input logic [7:0] exp_b);
    logic [7:0] na;
    logic [7:0] nb;
    na = 8'h00;
    nb = 8'h00;
    repeat (24) @(negedge ref_clk_in);
    repeat (150) begin
      @(negedge ref_clk_in);
      na = na + 8'(lit[0]);
      nb = nb + 8'(lit[1]);
    end
    chk(na, exp_a);
    chk(nb, exp_b);
  endtask : duty

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_regs();
    logic [3:0] a[6] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
    logic [7:0] e[6] = '{8'h44, 8'h44, 8'hFF, 8'h0F, 8'h00, 8'h00};
    wr(4'hB, 8'h5A);
    for (int i = 0; i < 6; i++) begin
      rd_chk(a[i], e[i]);
    end
  endtask : t_reset_regs

  // Pin 0 on the master level, ten lit cycles per code step; pin 1 fully on
  task automatic t_master();
    logic [3:0] n[4] = '{4'h0, 4'h1, 4'h8, 4'hF};
    set_sel(8'h01, 8'h00, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(4'h9, {4'h0, n[i]});
      duty(8'(n[i]) * 8'd10, 8'd150);
    end
  endtask : t_master

  // Fixed-peak modes, then each bank switched to the master level
  task automatic t_fixed_peak();
    set_sel(8'h02, 8'h03, 8'h00);
    wr(4'h8, 8'h3C);
    duty(8'd120, 8'd30);
    wr(4'h9, 8'h15);
    duty(8'd50, 8'd30);
    wr(4'h9, 8'h35);
    duty(8'd50, 8'd50);
  endtask : t_fixed_peak

  // Start regions picked by the init register; long regions hold steady
  task automatic t_regions();
    logic [7:0] code[5] = '{8'h9B, 8'hB9, 8'h0D, 8'hF0, 8'hD7};
    logic [7:0] ea[5]   = '{8'd0, 8'd90, 8'd90, 8'd90, 8'd90};
    logic [7:0] eb[5]   = '{8'd60, 8'd0, 8'd0, 8'd0, 8'd60};
    wr(4'h9, 8'h00);
    wr(4'h8, 8'h69);
    wr(4'h4, 8'hFF);
    wr(4'h6, 8'hFF);
    wr(4'h7, 8'hFF);
    set_sel(8'h02, 8'h03, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(4'hA, code[i]);
      duty(ea[i], eb[i]);
    end
  endtask : t_regions

  // One-shot over a short fully-on region, then a pin joins the running bank
  task automatic t_oneshot();
    wr(4'h9, 8'h40);
    wr(4'h4, 8'hF1);
    wr(4'h5, 8'hF1);
    set_sel(8'h00, 8'h01, 8'h01);
    wr(4'hA, 8'h09);
    repeat (100) @(negedge ref_clk_in);
    rd_chk(lbc_pkg::OFS_SEL_HI, 8'h00);
    rd_chk(lbc_pkg::OFS_SEL_MID, 8'h01);
    rd_chk(lbc_pkg::OFS_SEL_LO, 8'h00);
    duty(8'd90, 8'd0);
    wr(lbc_pkg::OFS_SEL_MID, 8'h03);
    wr(lbc_pkg::OFS_SEL_HI, 8'h02);
    duty(8'd90, 8'd0);
  endtask : t_oneshot

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge ref_clk_in);
    srst_in = 1'b0;
    t_reset_regs();
    t_master();
    t_fixed_peak();
    t_regions();
    t_oneshot();
    end_sim();
  end
endmodule : tb_top
